// *** src/csi_ctrl.sv ***
// Charger status, switch routing, interrupt pin and I2C register slave.
// All status inputs and the I2C pins are asynchronous to mclk_in.
// Notes on behaviour
// R01 - Charge enable follows charger type and compliance
// R02 - Accessory change reported after 30 ms stability
// R03 - Overvoltage opens supply switch, flags fault
// R04 - Thermal shutdown stops, recovers and clears itself
// R05 - Interrupt sources: supply, timeout, overvoltage, thermal, accessory
// R06 - Disabled output masks pin, keeps pending bits
// R07 - Pending cleared after both status registers read
// R08 - Disabled interrupt turns pin into fault flag
// R09 - Invalid or unknown charger pulls pin low
// R10 - Level mode holds pin until status cleared
// R11 - Polarity bit sets active pin level
// R12 - Host reads all status, then rechecks line
// R13 - Edge mode pulses with selectable width
// R14 - New event restarts the running pulse
// R15 - Sleep stops oscillator only when fully idle
// R16 - Sleep opens every data switch
// R17 - Awake keeps oscillator and bandgap running
// R18 - Data lines routed to USB or serial
// R19 - No supply releases outputs; default output states
// R20 - ID buffer grounds, drives supply, or floats
// R21 - Transfers: start, address, pointer, data, stop
// R22 - Clock is input only, data open drain
// R23 - Slave answers to address 0110101
// R24 - Pointer first, then auto-incrementing data
// R25 - Timers count system clock, debounce restarts
// R26 - Every source latches its own pending bit
`timescale 1ns/10ps
module csi_ctrl
    import csi_pkg::*;
#(
    parameter int unsigned         DEB_CYCLES  = DEB_CYC,
    parameter logic [PULSE_W-1:0]  PULSE_SHORT = PULSE_W'(PULSE_SHORT_CYC),
    parameter logic [PULSE_W-1:0]  PULSE_LONG  = PULSE_W'(PULSE_LONG_CYC)
) (
    // Clock and reset
    input  wire logic       mclk_in,
    input  wire logic       rst_b_in,
    // I2C pins
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_b_out,
    // Detector status
    input  wire logic       bus_supply_in,
    input  wire logic       contact_timeout_in,
    input  wire logic       overvoltage_in,
    input  wire logic       thermal_shutdown_in,
    input  wire logic [2:0] id_state_in,
    input  wire logic [3:0] id_level_code_in,
    input  wire logic [3:0] charger_type_code_in,
    input  wire logic       compliance_select_in,
    // Pin controls
    output logic            charge_en_out,
    output logic            charge_en_oe_b_out,
    output logic            supply_switch_on_out,
    output logic [1:0]      data_route_out,
    output logic            id_buffer_out,
    output logic            id_buffer_oe_b_out,
    output logic            irq_out,
    output logic            irq_oe_b_out,
    output logic            osc_run_out,
    output logic            bandgap_on_out
);
    localparam int unsigned SW = $bits(csi_sens_s);

    logic [SW-1:0]      s1_r, s2_r, s3_r, stab_r;
    csi_sens_s          sn;
    csi_ctrl_s          ctrl_r;
    csi_sens_s          prev_r;
    logic [EV_N-1:0]    ev, pend_r, clr_mask;
    csi_id_e            cand_r, acc_r;
    logic [DEB_W-1:0]   deb_cnt_r;
    logic               acc_ev;
    logic               rd1_r, rd2_r, clr_both;
    logic [PULSE_W-1:0] pulse_r, pw_cyc;
    logic               irq_act, irq_low, bad_chg;
    csi_i2c_e           ist_r;
    logic [3:0]         bit_r;
    logic [7:0]         sh_r, tx_r, ptr_r, rd_val;
    logic               addr_ph_r, ptr_ph_r, rw_r, nack_r, sda_low_r;
    logic               scl_q_r, sda_q_r;
    logic               rise, fall, start, stop;
    logic               byte_in, wr_stb, rd_stb;

    function automatic logic [7:0] rd_mux(input logic [7:0] a,
            input logic [EV_N-1:0] p, input csi_ctrl_s c);
        case (a)
            REG_STAT1: rd_mux = {4'h0, p[EV_TS:EV_VB]};
            REG_STAT2: rd_mux = {7'h00, p[EV_ACC]};
            REG_CTRL:  rd_mux = c;
            default:   rd_mux = RD_NONE;
        endcase
    endfunction

    // Charge enable is released (1) only when off, or SDP when compliant.
    function automatic logic ce_map(input logic [3:0] t, input logic c);
        case (t)
            CHG_OFF: ce_map = 1'b1;
            CHG_SDP: ce_map = c;
            default: ce_map = 1'b0;
        endcase
    endfunction

    // Three-stage synchroniser; a bit moves once stages two and three agree.
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= {scl_in, sda_in, bus_supply_in, contact_timeout_in,
                     overvoltage_in, thermal_shutdown_in, id_state_in,
                     id_level_code_in, charger_type_code_in,
                     compliance_select_in};
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    for (genvar i = 0; i < SW; i++) begin : g_agree
        always_ff @(posedge mclk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
                stab_r[i] <= 1'b0;
            end else if (s2_r[i] == s3_r[i]) begin
                stab_r[i] <= s3_r[i];
            end
        end
    end
    assign sn = csi_sens_s'(stab_r);

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            prev_r <= '0;
        end else begin
            prev_r <= sn;
        end
    end

    // Accessory debounce restarts whenever the ID state moves.
    assign acc_ev = (sn.id_state == cand_r) && (cand_r != acc_r) &&
                    (deb_cnt_r == DEB_W'(DEB_CYCLES - 1));
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cand_r    <= ID_INVALID;
            acc_r     <= ID_INVALID;
            deb_cnt_r <= '0;
        end else if (sn.id_state != cand_r) begin
            cand_r    <= sn.id_state;                 // [R25]
            deb_cnt_r <= '0;
        end else if (acc_ev) begin
            acc_r     <= cand_r;                      // [R02]
        end else if (cand_r != acc_r) begin
            deb_cnt_r <= deb_cnt_r + 1'b1;
        end
    end

    assign ev[EV_VB]  = sn.bus_supply_valid_status
                      ^ prev_r.bus_supply_valid_status;   // [R05]
    assign ev[EV_DCD] = sn.contact_timeout_status
                      & ~prev_r.contact_timeout_status;   // [R05]
    assign ev[EV_OV]  = sn.overvoltage & ~prev_r.overvoltage;
    assign ev[EV_TS]  = sn.thermal_shutdown & ~prev_r.thermal_shutdown;
    assign ev[EV_ACC] = acc_ev;

    // Thermal recovery withdraws its own pending bit.
    assign clr_both = rd1_r & rd2_r;
    always_comb begin
        clr_mask = {EV_N{clr_both}};                  // [R07]
        clr_mask[EV_TS] = clr_both | (prev_r.thermal_shutdown &
                          ~sn.thermal_shutdown);      // [R04]
    end

    // A new event wins over a clear in the same cycle.
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pend_r <= '0;
        end else begin
            pend_r <= (pend_r & ~clr_mask) | ev;      // [R26] [R06]
        end
    end

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rd1_r <= 1'b0;
            rd2_r <= 1'b0;
        end else if (clr_both) begin
            rd1_r <= 1'b0;
            rd2_r <= 1'b0;
        end else if (rd_stb) begin
            rd1_r <= rd1_r | (ptr_r == REG_STAT1);
            rd2_r <= rd2_r | (ptr_r == REG_STAT2);
        end
    end

    assign pw_cyc = ctrl_r.irq_pulse_width ? PULSE_LONG : PULSE_SHORT;
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pulse_r <= '0;
        end else if (ctrl_r.irq_en && ctrl_r.irq_type && |ev) begin
            pulse_r <= pw_cyc;                        // [R13] [R14]
        end else if (pulse_r != '0) begin
            pulse_r <= pulse_r - 1'b1;
        end
    end

    assign bad_chg = sn.bus_supply_valid_status &&
                     (acc_r == ID_INVALID || acc_r == ID_UNKNOWN);
    assign irq_act = ctrl_r.irq_en &&
                     (ctrl_r.irq_type ? (pulse_r != '0)
                                      : |pend_r);     // [R10] [R06]
    always_comb begin
        if (bad_chg) begin
            irq_low = 1'b1;                           // [R09]
        end else if (!ctrl_r.irq_en) begin
            irq_low = sn.overvoltage | sn.thermal_shutdown;  // [R08]
        end else begin
            irq_low = irq_act ^ ctrl_r.irq_polarity;  // [R11]
        end
    end

    // Pin and switch controls, all registered.
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            irq_oe_b_out         <= 1'b1;
            charge_en_oe_b_out   <= 1'b1;
            supply_switch_on_out <= 1'b0;
            data_route_out       <= ROUTE_OPEN;
            id_buffer_out        <= 1'b0;
            id_buffer_oe_b_out   <= 1'b1;
        end else begin
            irq_oe_b_out <= ~irq_low;
            charge_en_oe_b_out <= ~sn.bus_supply_valid_status |
                ce_map(sn.charger_type_code,
                       sn.compliance_select);         // [R01] [R19]
            supply_switch_on_out <= sn.bus_supply_valid_status &&
                acc_r != ID_UART && !sn.overvoltage &&  // [R03] [R19]
                !sn.thermal_shutdown;                 // [R04]
            if (ctrl_r.sleep_select || !sn.bus_supply_valid_status) begin
                data_route_out <= ROUTE_OPEN;         // [R16] [R19]
            end else if (ctrl_r.switch_route_select != ROUTE_OPEN) begin
                data_route_out <= ctrl_r.switch_route_select;
            end else if (acc_r == ID_UART || acc_r == ID_UART_FAC) begin
                data_route_out <= ROUTE_UART;         // [R18]
            end else if (acc_r == ID_INVALID) begin
                data_route_out <= ROUTE_OPEN;
            end else begin
                data_route_out <= ROUTE_USB;          // [R18]
            end
            id_buffer_out <= acc_r != ID_OTG;         // [R20]
            id_buffer_oe_b_out <= !(sn.bus_supply_valid_status &&
                (acc_r == ID_OTG || acc_r == ID_USB_FAC ||
                 acc_r == ID_UART_FAC));              // [R20]
        end
    end

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            osc_run_out    <= 1'b1;
            bandgap_on_out <= 1'b1;
        end else begin
            osc_run_out <= !(ctrl_r.sleep_select &&
                !sn.bus_supply_valid_status &&
                ctrl_r.switch_route_select == ROUTE_OPEN &&
                !ctrl_r.charge_pump_on &&
                sn.id_level_code == ID_LEVEL_OPEN);   // [R15] [R17]
            bandgap_on_out <= !ctrl_r.sleep_select;   // [R17]
        end
    end

    assign charge_en_out = 1'b0;
    assign irq_out       = 1'b0;
    assign sda_out       = 1'b0;
    assign sda_oe_b_out  = ~sda_low_r;                // [R22]

    // I2C bit events from the stable copies of SCL and SDA.
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            scl_q_r <= sn.scl;
            sda_q_r <= sn.sda;
        end
    end
    assign rise  = sn.scl & ~scl_q_r;
    assign fall  = ~sn.scl & scl_q_r;
    assign start = sn.scl & scl_q_r & sda_q_r & ~sn.sda;  // [R21]
    assign stop  = sn.scl & scl_q_r & ~sda_q_r & sn.sda;  // [R21]
    assign byte_in = ist_r == I_RX && fall && bit_r == BIT_BYTE;
    assign wr_stb  = byte_in && !addr_ph_r && !ptr_ph_r;
    assign rd_stb  = fall && ((ist_r == I_RACK && rw_r) ||
                              (ist_r == I_TACK && !nack_r));
    assign rd_val  = rd_mux(ptr_r, pend_r, ctrl_r);

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ist_r <= I_IDLE;
            bit_r <= '0;
            sh_r <= '0;
            tx_r <= '0;
            addr_ph_r <= 1'b0;
            ptr_ph_r <= 1'b0;
            rw_r <= 1'b0;
            nack_r <= 1'b0;
            sda_low_r <= 1'b0;
        end else if (start) begin
            ist_r <= I_RX;
            bit_r <= '0;
            addr_ph_r <= 1'b1;
            sda_low_r <= 1'b0;
        end else if (stop) begin
            ist_r <= I_IDLE;
            sda_low_r <= 1'b0;
        end else begin
            case (ist_r)
                I_RX: begin
                    if (rise) begin
                        sh_r  <= {sh_r[6:0], sn.sda};
                        bit_r <= bit_r + 1'b1;
                    end else if (byte_in) begin
                        bit_r <= '0;
                        if (!addr_ph_r || sh_r[7:1] == I2C_ADDR) begin
                            sda_low_r <= 1'b1;        // [R23]
                            ist_r     <= I_RACK;
                        end else begin
                            ist_r <= I_IDLE;
                        end
                        if (addr_ph_r) begin
                            rw_r     <= sh_r[0];
                            ptr_ph_r <= ~sh_r[0];     // [R24]
                        end else begin
                            ptr_ph_r <= 1'b0;
                        end
                    end
                end
                I_RACK, I_TACK: begin
                    if (rise) begin
                        nack_r <= sn.sda;
                    end else if (fall) begin
                        addr_ph_r <= 1'b0;
                        sda_low_r <= 1'b0;
                        if (rd_stb) begin
                            ist_r     <= I_TX;
                            tx_r      <= rd_val;
                            sda_low_r <= ~rd_val[7];
                        end else begin
                            ist_r <= rw_r ? I_IDLE : I_RX;
                        end
                    end
                end
                I_TX: begin
                    if (fall && bit_r == BIT_LAST) begin
                        bit_r     <= '0;
                        sda_low_r <= 1'b0;
                        ist_r     <= I_TACK;
                    end else if (fall) begin
                        tx_r      <= {tx_r[6:0], 1'b0};
                        sda_low_r <= ~tx_r[6];
                        bit_r     <= bit_r + 1'b1;
                    end
                end
                default: ist_r <= I_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ptr_r <= '0;
        end else if (byte_in && !addr_ph_r && ptr_ph_r) begin
            ptr_r <= sh_r;                            // [R24]
        end else if (wr_stb || rd_stb) begin
            ptr_r <= ptr_r + 1'b1;                    // [R24]
        end
    end

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ctrl_r <= CTRL_RESET;
        end else if (wr_stb && ptr_r == REG_CTRL) begin
            ctrl_r <= csi_ctrl_s'(sh_r);
        end
    end

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);

    a_ce_map: assert property ( // [R01]
        sn.bus_supply_valid_status && sn.charger_type_code == CHG_SDP
        |=> charge_en_oe_b_out == $past(sn.compliance_select))
        else $error("charge enable does not follow compliance");
    a_ov_open: assert property ( // [R03]
        sn.overvoltage |=> !supply_switch_on_out)
        else $error("supply switch closed during overvoltage");
    a_pend_keep: assert property ( // [R06]
        pend_r[EV_VB] && !clr_both |=> pend_r[EV_VB])
        else $error("pending bit lost without clearing reads");
    a_clear_both: assert property ( // [R07]
        $past(pend_r[EV_OV]) && !pend_r[EV_OV] |-> $past(clr_both))
        else $error("pending bit cleared without both reads");
    a_level_hold: assert property ( // [R10]
        ctrl_r.irq_en && !ctrl_r.irq_type && |pend_r && !bad_chg
        |=> irq_oe_b_out == $past(ctrl_r.irq_polarity))
        else $error("level interrupt not at active level");
    a_edge_width: assert property ( // [R14]
        ctrl_r.irq_en && ctrl_r.irq_type && |ev
        |=> pulse_r == $past(pw_cyc))
        else $error("edge pulse not restarted at full width");
    a_sleep_open: assert property ( // [R16]
        ctrl_r.sleep_select |=> data_route_out == ROUTE_OPEN)
        else $error("switch closed in sleep");
    a_osc_awake: assert property ( // [R17]
        !ctrl_r.sleep_select |=> osc_run_out && bandgap_on_out)
        else $error("oscillator stopped while awake");
    a_addr_ack: assert property ( // [R23]
        byte_in && addr_ph_r && sh_r[7:1] == I2C_ADDR
        |=> !sda_oe_b_out [*2])
        else $error("own address not acknowledged");

    c_edge_ext: cover property (pulse_r != '0 && |ev && ctrl_r.irq_type);
    c_rd_clear: cover property (clr_both && |pend_r);
    c_osc_stop: cover property (!osc_run_out);
    c_acc_change: cover property (acc_ev);
endmodule // csi_ctrl

// *** src/csi_pkg.sv ***
// Constants, register map and types of the charger status controller.
// Assumes a 125 MHz system clock; the bench imports it as well.
package csi_pkg;
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned DEB_TIME_MS   = 30;
    localparam int unsigned DEB_CYC =
        DEB_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned PULSE_SHORT_US = 1;
    localparam int unsigned PULSE_LONG_US  = 10;
    localparam int unsigned PULSE_SHORT_CYC =
        PULSE_SHORT_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned PULSE_LONG_CYC =
        PULSE_LONG_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned DEB_W   = 22;
    localparam int unsigned PULSE_W = 16;

    localparam logic [6:0] I2C_ADDR   = 7'h35;
    localparam logic [7:0] REG_STAT1  = 8'h01;
    localparam logic [7:0] REG_STAT2  = 8'h02;
    localparam logic [7:0] REG_CTRL   = 8'h07;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] RD_NONE    = 8'h00;
    localparam logic [3:0] BIT_LAST   = 4'h7;
    localparam logic [3:0] BIT_BYTE   = 4'h8;

    localparam logic [3:0] CHG_OFF = 4'h0;
    localparam logic [3:0] CHG_SDP = 4'h1;
    localparam logic [3:0] ID_LEVEL_OPEN = 4'hF;

    // Pending event bits; status one holds the first four.
    localparam int unsigned EV_N   = 5;
    localparam int unsigned EV_VB  = 0;
    localparam int unsigned EV_DCD = 1;
    localparam int unsigned EV_OV  = 2;
    localparam int unsigned EV_TS  = 3;
    localparam int unsigned EV_ACC = 4;

    typedef enum logic [2:0] {
        ID_INVALID  = 3'h0,
        ID_OTG      = 3'h1,
        ID_UART     = 3'h2,
        ID_USB_FAC  = 3'h3,
        ID_UART_FAC = 3'h4,
        ID_UNKNOWN  = 3'h5,
        ID_CHARGER  = 3'h6,
        ID_USB_DEV  = 3'h7
    } csi_id_e;

    typedef enum logic [1:0] {
        ROUTE_OPEN = 2'h0,
        ROUTE_USB  = 2'h1,
        ROUTE_UART = 2'h2
    } csi_route_e;

    typedef enum logic [2:0] {
        I_IDLE = 3'h0,
        I_RX   = 3'h1,
        I_RACK = 3'h2,
        I_TX   = 3'h3,
        I_TACK = 3'h4
    } csi_i2c_e;

    typedef struct packed {
        logic       irq_en;
        logic       irq_type;
        logic       irq_polarity;
        logic       irq_pulse_width;
        logic       charge_pump_on;
        logic       sleep_select;
        logic [1:0] switch_route_select;
    } csi_ctrl_s;

    typedef struct packed {
        logic       scl;
        logic       sda;
        logic       bus_supply_valid_status;
        logic       contact_timeout_status;
        logic       overvoltage;
        logic       thermal_shutdown;
        csi_id_e    id_state;
        logic [3:0] id_level_code;
        logic [3:0] charger_type_code;
        logic       compliance_select;
    } csi_sens_s;
endpackage

// *** tb/csi_host.sv ***
// Host microcontroller model: an I2C bus master run from the system clock.
// Assumes the bench resolves SDA as an open-drain wire with a pull-up.
`timescale 1ns/10ps
module csi_host
    import csi_pkg::*;
(
    // Clock and bus
    input  wire logic mclk_in,
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_out
);
    localparam int Q = 12;
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    task automatic tk(input int n);
        repeat (n) @(posedge mclk_in);
    endtask
    task automatic bo(input logic b);
        sda_out <= b;
        tk(Q);
        scl_out <= 1'b1;
        tk(2 * Q);
        scl_out <= 1'b0;
        tk(Q);
    endtask
    task automatic bi(output logic b);
        sda_out <= 1'b1;
        tk(Q);
        scl_out <= 1'b1;
        tk(Q);
        b = sda_in;
        tk(Q);
        scl_out <= 1'b0;
        tk(Q);
    endtask
    task automatic start;
        sda_out <= 1'b1;
        tk(Q);
        scl_out <= 1'b1;
        tk(Q);
        sda_out <= 1'b0;
        tk(Q);
        scl_out <= 1'b0;
        tk(Q);
    endtask
    task automatic stop;
        sda_out <= 1'b0;
        tk(Q);
        scl_out <= 1'b1;
        tk(Q);
        sda_out <= 1'b1;
        tk(2 * Q);
    endtask
    task automatic tx(input logic [7:0] v, output logic nk);
        for (int i = 7; i >= 0; i--) bo(v[i]);
        bi(nk);
    endtask
    task automatic rx(output logic [7:0] v, input logic nk);
        for (int i = 7; i >= 0; i--) bi(v[i]);
        bo(nk);
    endtask
    // Address, pointer, one data byte; nk is high if any byte went unacked.
    task automatic wr(input logic [6:0] a, input logic [7:0] p, d,
                      output logic nk);
        logic n1;
        logic n2;
        start();
        tx({a, 1'b0}, nk);
        tx(p, n1);
        tx(d, n2);
        nk = nk | n1 | n2;
        stop();
    endtask
    task automatic rd(input logic [7:0] p, output logic [7:0] v1, v2);
        logic n;
        start();
        tx({I2C_ADDR, 1'b0}, n);
        tx(p, n);
        start();
        tx({I2C_ADDR, 1'b1}, n);
        rx(v1, 1'b0);
        rx(v2, 1'b1);
        stop();
    endtask
endmodule // csi_host

// *** tb/tb.sv ***
// Self-checking bench of the charger status controller.
// Drives detector inputs and talks to the registers through the host model.
`timescale 1ns/10ps
module tb;
    import csi_pkg::*;
    localparam int PS = 4;
    localparam int PL = 10;
    logic mclk_in = 1'b0, rst_b_in = 1'b0, scl_in, sda_in, hsda, nk;
    logic bs = 1'b0, ct = 1'b0, ov = 1'b0, ts = 1'b0, cp = 1'b0;
    logic [2:0] id = 3'h7;
    logic [3:0] lv = 4'h0, cg = 4'h0;
    logic [7:0] v1, v2;
    logic [1:0] data_route_out;
    logic sda_out, sda_oe_b_out, charge_en_oe_b_out, supply_switch_on_out;
    logic id_buffer_out, id_buffer_oe_b_out, irq_oe_b_out;
    logic osc_run_out, bandgap_on_out;
    int mismatches = 0, checked = 0, n;
    logic [31:0] seed = 32'd71810;
    always #4 mclk_in = ~mclk_in;
    assign sda_in = hsda & (sda_oe_b_out | sda_out);
    csi_host host (.mclk_in, .sda_in, .scl_out(scl_in), .sda_out(hsda));
    csi_ctrl #(.DEB_CYCLES(20), .PULSE_SHORT(PULSE_W'(PS)),
        .PULSE_LONG(PULSE_W'(PL))) dut (.mclk_in, .rst_b_in, .scl_in,
        .sda_in, .sda_out, .sda_oe_b_out, .bus_supply_in(bs),
        .contact_timeout_in(ct), .overvoltage_in(ov),
        .thermal_shutdown_in(ts), .id_state_in(id), .id_level_code_in(lv),
        .charger_type_code_in(cg), .compliance_select_in(cp),
        .charge_en_out(), .charge_en_oe_b_out, .supply_switch_on_out,
        .data_route_out, .id_buffer_out, .id_buffer_oe_b_out, .irq_out(),
        .irq_oe_b_out, .osc_run_out, .bandgap_on_out);
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Charge enable stays released only for no charger or a compliant port.
    function automatic logic ce_hi(logic [3:0] c, logic p);
        return c == CHG_OFF || (c == CHG_SDP && p);
    endfunction
    task automatic go(input int k);
        repeat (k) @(posedge mclk_in);
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        if (mismatches == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic ctl(input logic [7:0] v);
        host.wr(I2C_ADDR, REG_CTRL, v, nk);
        chk(8'(nk), 8'h00);
    endtask
    // Fires a supply change now and optionally again at cycle gap.
    task automatic pulse(input int gap, input int exp);
        n = 0;
        for (int k = 0; k < 80; k++) begin
            if (k == 0 || k == gap) bs <= ~bs;
            go(1);
            n += int'(!irq_oe_b_out);
        end
        chk(8'(n), 8'(exp));
    endtask
    initial begin
        go(100000);
        mismatches++;
        conclude();
    end
    initial begin
        go(6);
        rst_b_in <= 1'b1;
        go(8);
        chk(8'({osc_run_out, bandgap_on_out}), 8'h03);
        chk(8'({charge_en_oe_b_out, data_route_out}), 8'h04);
        host.wr(7'h36, REG_CTRL, 8'hFF, nk);
        chk(8'(nk), 8'h01);
        host.rd(REG_CTRL, v1, v2);
        chk(v1, CTRL_RESET);
        chk(v2, RD_NONE);
        bs <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            cg <= (i < 2) ? CHG_SDP : (i == 2) ? CHG_OFF : 4'(xs());
            cp <= (i < 2) ? i[0] : 1'(xs());
            go(10);
            chk(8'(charge_en_oe_b_out), 8'(ce_hi(cg, cp)));
        end
        for (int i = 1; i < 8; i++) begin
            id <= 3'(i);
            go(40);
            chk(8'(data_route_out), (i == 2 || i == 4) ? 8'h02 : 8'h01);
            chk(8'({id_buffer_oe_b_out, id_buffer_oe_b_out | id_buffer_out}),
                i == 1 ? 8'h00 : (i == 3 || i == 4) ? 8'h01 : 8'h03);
            chk(8'(supply_switch_on_out), 8'(i != 2));
            chk(8'(irq_oe_b_out), 8'(i != 5));
        end
        host.rd(REG_STAT1, v1, v2);
        chk(v1, 8'h01);
        chk(v2, 8'h01);
        id <= ID_CHARGER;
        go(10);
        id <= ID_USB_DEV;
        go(40);
        host.rd(REG_STAT1, v1, v2);
        chk(v1, 8'h00);
        chk(v2, 8'h00);
        ctl(8'h80);
        host.rd(REG_CTRL, v1, v2);
        chk(v1, 8'h80);
        ct <= 1'b1;
        go(10);
        chk(8'(irq_oe_b_out), 8'h00);
        ct <= 1'b0;
        host.rd(8'h00, v1, v2);
        chk(v2, 8'h02);
        chk(8'(irq_oe_b_out), 8'h00);
        host.rd(REG_STAT1, v1, v2);
        chk(v1, 8'h02);
        go(10);
        chk(8'(irq_oe_b_out), 8'h01);
        ctl(8'hA0);
        chk(8'(irq_oe_b_out), 8'h00);
        ctl(8'h00);
        ov <= 1'b1;
        go(10);
        chk(8'({supply_switch_on_out, irq_oe_b_out}), 8'h00);
        ov <= 1'b0;
        ts <= 1'b1;
        go(10);
        chk(8'(irq_oe_b_out), 8'h00);
        ts <= 1'b0;
        bs <= 1'b0;
        ctl(8'h80);
        chk(8'(irq_oe_b_out), 8'h00);
        host.rd(REG_STAT1, v1, v2);
        chk(v1, 8'h05);
        ctl(8'hC0);
        pulse(99, PS);
        ctl(8'hD0);
        pulse(5, 5 + PL);
        bs <= 1'b1;
        ctl(8'h04);
        chk(8'({data_route_out, osc_run_out, bandgap_on_out}), 8'h02);
        bs <= 1'b0;
        lv <= ID_LEVEL_OPEN;
        go(10);
        chk(8'(osc_run_out), 8'h00);
        lv <= 4'h0;
        go(10);
        chk(8'(osc_run_out), 8'h01);
        ctl(8'h00);
        chk(8'(bandgap_on_out), 8'h01);
        conclude();
    end
endmodule // tb
